/* logic/ecso_pkg.sv */
// Constants shared by the event tally and status pin block.
// Assumes a 32-bit classic Wishbone slave, one word per register index.
package ecso_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ECSO_AW = 10;
    localparam int ECSO_DW = 32;

    // ==========================================================
    // Register indices, byte address is four times the index
    localparam logic [7:0] ECSO_IDX_TALLY_ONE = 8'h51;
    localparam logic [7:0] ECSO_IDX_TALLY_TWO = 8'h52;
    localparam logic [7:0] ECSO_IDX_INPUT_EN = 8'h53;
    localparam logic [7:0] ECSO_IDX_LEVEL_MON = 8'h54;
    localparam logic [7:0] ECSO_IDX_STATUS_CTL = 8'h55;

    // ==========================================================
    // Field positions
    localparam int ECSO_EN_ONE_BIT = 0;
    localparam int ECSO_EN_TWO_BIT = 1;
    localparam int ECSO_MON_ONE_BIT = 5;
    localparam int ECSO_MON_TWO_BIT = 6;
    localparam int ECSO_CTL_STATIC_EN_BIT = 7;
    localparam int ECSO_CTL_STATIC_VAL_BIT = 6;
    localparam int ECSO_CTL_INV_BIT = 3;
    localparam int ECSO_CTL_SEL_LSB = 0;

    // ==========================================================
    // Reset values and limits
    localparam logic [5:0] ECSO_TALLY_RESET = 6'h00;
    localparam logic [5:0] ECSO_TALLY_MAX = 6'h3f;
    localparam logic [5:0] ECSO_TALLY_STEP = 6'h01;
    localparam logic [1:0] ECSO_EN_RESET = 2'h0;
    localparam logic [7:0] ECSO_CTL_RESET = 8'h00;
    localparam logic [7:0] ECSO_CTL_WMASK = 8'hcf;

    // ==========================================================
    // Status flag selector codes
    localparam logic [2:0] ECSO_SEL_TIMER = 3'h0;
    localparam logic [2:0] ECSO_SEL_ALARM = 3'h1;
    localparam logic [2:0] ECSO_SEL_UPDATE = 3'h2;
    localparam logic [2:0] ECSO_SEL_EVENT = 3'h3;
    localparam logic [2:0] ECSO_SEL_TEMP = 3'h4;
    localparam logic [2:0] ECSO_SEL_INVALID = 3'h5;

endpackage

/* logic/ecso_top.sv */
// Event tally counters, pin level monitor and status output pin.
// Assumes event pins are asynchronous and internal flags are on clk_i.
module ecso_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [ecso_pkg::ECSO_AW-1:0] adr_i,
    input wire logic [ecso_pkg::ECSO_DW-1:0] dat_i,
    output logic [ecso_pkg::ECSO_DW-1:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    // Event input pins
    input wire logic event_input_one_i,
    input wire logic event_input_two_i,
    // Internal status flags
    input wire logic wakeup_timer_flag_i,
    input wire logic alarm_flag_i,
    input wire logic time_update_flag_i,
    input wire logic event_detect_flag_i,
    input wire logic temp_comp_stop_flag_i,
    input wire logic invalid_time_flag_i,
    // Status output pin
    output logic status_out_pin_o,
    output logic status_out_pin_oe_n_o
);
    import ecso_pkg::*;

    // ==========================================================
    // Declarations
    logic [1:0] sync_one;
    logic [1:0] sync_two;
    logic prev_one;
    logic prev_two;
    logic hit_one;
    logic hit_two;
    logic [5:0] tally_one;
    logic [5:0] tally_two;
    logic [1:0] input_en;
    logic [7:0] status_ctl;
    logic take;
    logic wr_take;
    logic [7:0] word_idx;
    logic [7:0] next_rdata;
    logic sel_flag;
    logic next_pin;
    logic next_oe_n;

    // Word index decode, used by both read and write paths
    function automatic logic [7:0] word_index(input logic [ECSO_AW-1:0] a);
        word_index = a[9:2];
    endfunction

    // Tally step with wrap past the top count
    function automatic logic [5:0] tally_next(input logic [5:0] t);
        if (t == ECSO_TALLY_MAX) begin
            tally_next = ECSO_TALLY_RESET;
        end else begin
            tally_next = t + ECSO_TALLY_STEP;
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    // Two stages per pin; only stage one reads stage zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_one <= 2'h0;
            sync_two <= 2'h0;
        end else begin
            sync_one <= {sync_one[0], event_input_one_i};
            sync_two <= {sync_two[0], event_input_two_i};
        end
    end

    // Edge history taken from the settled stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_one <= 1'b0;
            prev_two <= 1'b0;
        end else begin
            prev_one <= sync_one[1];
            prev_two <= sync_two[1];
        end
    end

    // Qualified event is a rising level seen while enabled
    assign hit_one = sync_one[1] & ~prev_one & input_en[ECSO_EN_ONE_BIT];
    assign hit_two = sync_two[1] & ~prev_two & input_en[ECSO_EN_TWO_BIT];

    // ==========================================================
    // Tally counters
    // Disabled inputs keep their count; no software clear exists
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tally_one <= ECSO_TALLY_RESET;
        end else if (hit_one) begin
            tally_one <= tally_next(tally_one);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tally_two <= ECSO_TALLY_RESET;
        end else if (hit_two) begin
            tally_two <= tally_next(tally_two);
        end
    end

    // ==========================================================
    // Bus handshake
    // Answer one cycle after the request; ack never stays two cycles
    assign take = cyc_i & stb_i & ~ack_o;
    assign wr_take = take & we_i & sel_i[0];
    assign word_idx = word_index(adr_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= take;
        end
    end

    // ==========================================================
    // Writable registers
    // Tallies and monitor are read-only, writes to them are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_en <= ECSO_EN_RESET;
        end else if (wr_take && word_idx == ECSO_IDX_INPUT_EN) begin
            input_en <= dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ctl <= ECSO_CTL_RESET;
        end else if (wr_take && word_idx == ECSO_IDX_STATUS_CTL) begin
            status_ctl <= dat_i[7:0] & ECSO_CTL_WMASK; // Unused bits stay zero
        end
    end

    // ==========================================================
    // Read mux
    // Unmapped words answer with zero rather than an error
    always_comb begin
        next_rdata = 8'h00;
        case (word_idx)
            ECSO_IDX_TALLY_ONE: next_rdata = {2'h0, tally_one};
            ECSO_IDX_TALLY_TWO: next_rdata = {2'h0, tally_two};
            ECSO_IDX_INPUT_EN: next_rdata = {6'h00, input_en};
            ECSO_IDX_LEVEL_MON: begin
                next_rdata[ECSO_MON_ONE_BIT] = sync_one[1];
                next_rdata[ECSO_MON_TWO_BIT] = sync_two[1];
            end
            ECSO_IDX_STATUS_CTL: next_rdata = status_ctl;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (take) begin
            dat_o <= {24'h00_0000, next_rdata};
        end
    end

    // ==========================================================
    // Status flag selection
    // Reserved codes give a quiet low flag instead of a guess
    always_comb begin
        case (status_ctl[ECSO_CTL_SEL_LSB +: 3])
            ECSO_SEL_TIMER: sel_flag = wakeup_timer_flag_i;
            ECSO_SEL_ALARM: sel_flag = alarm_flag_i;
            ECSO_SEL_UPDATE: sel_flag = time_update_flag_i;
            ECSO_SEL_EVENT: sel_flag = event_detect_flag_i;
            ECSO_SEL_TEMP: sel_flag = temp_comp_stop_flag_i;
            ECSO_SEL_INVALID: sel_flag = invalid_time_flag_i;
            default: sel_flag = 1'b0;
        endcase
    end

    // Output mode decode from the enable and value bits
    always_comb begin
        next_pin = 1'b0;
        next_oe_n = 1'b1; // Hi-Z unless a mode drives
        if (status_ctl[ECSO_CTL_STATIC_EN_BIT]) begin
            next_oe_n = 1'b0;
            next_pin = status_ctl[ECSO_CTL_STATIC_VAL_BIT];
        end else if (status_ctl[ECSO_CTL_STATIC_VAL_BIT]) begin
            next_oe_n = 1'b0;
            next_pin = sel_flag ^ status_ctl[ECSO_CTL_INV_BIT];
        end
    end

    // Registered pin drive keeps the output glitch free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_out_pin_o <= 1'b0;
            status_out_pin_oe_n_o <= 1'b1;
        end else begin
            status_out_pin_o <= next_pin;
            status_out_pin_oe_n_o <= next_oe_n;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_request;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence seq_answer;
        ack_o ##1 !ack_o;
    endsequence

    sequence seq_flag_mode;
        !status_ctl[ECSO_CTL_STATIC_EN_BIT] && status_ctl[ECSO_CTL_STATIC_VAL_BIT];
    endsequence

    sequence seq_ctl_write;
        cyc_i && stb_i && !ack_o && we_i && word_idx == ECSO_IDX_STATUS_CTL;
    endsequence

    property p_bus_answer;
        seq_request |=> seq_answer;
    endproperty

    property p_step(logic h, logic [5:0] t);
        h && t != ECSO_TALLY_MAX |=> t == $past(t) + ECSO_TALLY_STEP;
    endproperty

    bus_ack_pulse_a: assert property (p_bus_answer)
        else $error("ack not a single pulse after request");

    tally_one_step_a: assert property (p_step(hit_one, tally_one))
        else $error("tally one did not step by one");

    tally_two_step_a: assert property (p_step(hit_two, tally_two))
        else $error("tally two did not step by one");

    tally_wrap_a: assert property (
        hit_one && tally_one == ECSO_TALLY_MAX |=> tally_one == ECSO_TALLY_RESET)
        else $error("tally one did not wrap to zero");

    tally_hold_a: assert property (
        !input_en[ECSO_EN_TWO_BIT] |=> $stable(tally_two))
        else $error("disabled tally two moved");

    tally_read_a: assert property (
        seq_request and (!we_i && word_idx == ECSO_IDX_TALLY_ONE)
        |=> ack_o && dat_o[7:6] == 2'h0 && dat_o[5:0] == $past(tally_one))
        else $error("tally one read wrong");

    monitor_read_a: assert property (
        seq_request and (!we_i && word_idx == ECSO_IDX_LEVEL_MON)
        |=> dat_o[ECSO_MON_TWO_BIT] == $past(sync_two[1]))
        else $error("monitor bit wrong");

    pin_hiz_a: assert property (
        !status_ctl[ECSO_CTL_STATIC_EN_BIT] && !status_ctl[ECSO_CTL_STATIC_VAL_BIT]
        |=> status_out_pin_oe_n_o)
        else $error("pin driven in Hi-Z mode");

    pin_static_a: assert property (
        status_ctl[ECSO_CTL_STATIC_EN_BIT]
        |=> !status_out_pin_oe_n_o && status_out_pin_o == $past(status_ctl[ECSO_CTL_STATIC_VAL_BIT]))
        else $error("static level wrong");

    pin_flag_a: assert property (
        seq_flag_mode |=> !status_out_pin_oe_n_o
        && status_out_pin_o == ($past(sel_flag) ^ $past(status_ctl[ECSO_CTL_INV_BIT])))
        else $error("flag output wrong");

    pin_reserved_a: assert property (
        seq_flag_mode and (status_ctl[2:1] == 2'h3)
        |=> status_out_pin_o == $past(status_ctl[ECSO_CTL_INV_BIT]))
        else $error("reserved selector not quiet");

    // Each tally gets the wrap or hold check that only the other tally had above
    tally_two_wrap_a: assert property (
        hit_two && tally_two == ECSO_TALLY_MAX |=> tally_two == ECSO_TALLY_RESET)
        else $error("tally two did not wrap to zero");

    tally_one_hold_a: assert property (
        !input_en[ECSO_EN_ONE_BIT] |=> $stable(tally_one))
        else $error("disabled tally one moved");

    // Without a qualified edge a tally must not move, so no event counts twice
    tally_one_idle_a: assert property (
        !hit_one |=> $stable(tally_one))
        else $error("tally one moved without an event");

    tally_two_idle_a: assert property (
        !hit_two |=> $stable(tally_two))
        else $error("tally two moved without an event");

    // Reads must return the count held when the request was taken
    tally_two_read_a: assert property (
        seq_request and (!we_i && word_idx == ECSO_IDX_TALLY_TWO)
        |=> ack_o && dat_o[7:6] == 2'h0 && dat_o[5:0] == $past(tally_two))
        else $error("tally two read wrong");

    monitor_one_read_a: assert property (
        seq_request and (!we_i && word_idx == ECSO_IDX_LEVEL_MON)
        |=> dat_o[ECSO_MON_ONE_BIT] == $past(sync_one[1]) && dat_o[4:0] == 5'h00 && !dat_o[7])
        else $error("monitor bit one or spare bits wrong");

    // Control writes land masked, and a write with byte lane 0 off leaves it alone
    ctl_write_a: assert property (
        seq_ctl_write and (sel_i[0]) |=> status_ctl == ($past(dat_i[7:0]) & ECSO_CTL_WMASK))
        else $error("control write did not land");

    ctl_lane_off_a: assert property (
        seq_ctl_write and (!sel_i[0]) |=> $stable(status_ctl))
        else $error("control changed with lane 0 off");

    bus_idle_a: assert property (
        !(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");

endmodule

/* test/ecso_far_side.sv */
// Far side model: the two event pulse sources and the status pin receiver.
// Assumes the bench calls its tasks only after reset has been released.
module ecso_far_side (
    // Clock
    input wire logic clk_i,
    // Event pins into the block
    output logic ev_one_o,
    output logic ev_two_o,
    // Status pin as the block drives it
    input wire logic pin_i,
    input wire logic pin_oe_n_i,
    output logic wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last = 1'b0;
    // ==========================================================
    // Pins idle low; the receiver starts from a known level
    initial begin
        ev_one_o = 1'b0;
        ev_two_o = 1'b0;
    end
    // No pull on the wire: a released pin shows the inverse of its last level
    always @(posedge clk_i) begin
        if (pin_oe_n_i === 1'b0) begin
            last <= pin_i;
        end
    end
    assign wire_o = (pin_oe_n_i === 1'b0) ? pin_i : ~last;
    // ==========================================================
    // Two cycles high and two low, so the two-flop synchroniser never misses one
    task automatic pulse(input int which, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            if (which == 1) begin
                ev_one_o <= 1'b1;
            end else begin
                ev_two_o <= 1'b1;
            end
            repeat (2) @(posedge clk_i);
            ev_one_o <= 1'b0;
            ev_two_o <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // Static levels, held long enough to pass the synchroniser
    task automatic levels(input logic a, input logic b);
        @(posedge clk_i);
        ev_one_o <= a;
        ev_two_o <= b;
        repeat (5) @(posedge clk_i);
    endtask
endmodule

/* test/ecso_top_test.sv */
// Self-checking bench for the event tally and status pin block.
// Assumes the far side model in ecso_far_side and a Wishbone master here.
module ecso_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ecso_pkg::*;
    typedef struct {logic [7:0] ctl; logic [5:0] fl; logic pin; logic oe_n;} ecso_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ECSO_AW-1:0] adr = '0;
    logic [ECSO_DW-1:0] wdat = '0;
    logic [ECSO_DW-1:0] dat_o;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ack_o, pin, oe_n, ev1, ev2, wire_lvl;
    logic [5:0] fl = 6'h00;
    logic [31:0] q;
    int fail_count = 0;
    int n_checks = 0;
    // Flag order, bit 0 upward: timer, alarm, update, event, temp stop, invalid time
    ecso_row_t rows [15] = '{
        '{8'h00, 6'h3f, 1'b0, 1'b1}, '{8'h80, 6'h3f, 1'b0, 1'b0}, '{8'hc0, 6'h00, 1'b1, 1'b0},
        '{8'hc8, 6'h00, 1'b1, 1'b0}, '{8'h40, 6'h01, 1'b1, 1'b0}, '{8'h41, 6'h02, 1'b1, 1'b0},
        '{8'h42, 6'h04, 1'b1, 1'b0}, '{8'h43, 6'h08, 1'b1, 1'b0}, '{8'h44, 6'h10, 1'b1, 1'b0},
        '{8'h45, 6'h20, 1'b1, 1'b0}, '{8'h4d, 6'h1f, 1'b1, 1'b0}, '{8'h87, 6'h3f, 1'b0, 1'b0},
        '{8'h42, 6'h3b, 1'b0, 1'b0}, '{8'h4e, 6'h3f, 1'b1, 1'b0}, '{8'h47, 6'h3f, 1'b0, 1'b0}};
    ecso_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(dat_o), .we_i(we),
        .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o), .event_input_one_i(ev1),
        .event_input_two_i(ev2), .wakeup_timer_flag_i(fl[0]), .alarm_flag_i(fl[1]),
        .time_update_flag_i(fl[2]), .event_detect_flag_i(fl[3]), .temp_comp_stop_flag_i(fl[4]),
        .invalid_time_flag_i(fl[5]), .status_out_pin_o(pin), .status_out_pin_oe_n_o(oe_n));
    ecso_far_side i_far (.clk_i(clk_i), .ev_one_o(ev1), .ev_two_o(ev2), .pin_i(pin),
        .pin_oe_n_i(oe_n), .wire_o(wire_lvl));
    // ==========================================================
    // Clock at 40 MHz
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: saw %h, wanted %h", $time, msg, seen, exp);
        end
    endtask
    // One classic cycle; request held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= {idx, 2'b00};
        wdat <= {24'h00_0000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string msg);
        wb(1'b0, idx, 8'h00, 4'hf);
        chk(q, {24'h00_0000, exp}, msg);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Whole run is about five hundred cycles
    initial begin
        repeat (6000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end
    // ==========================================================
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(oe_n, 1'b1, "oe after reset");
        chk(ack_o, 1'b0, "ack after reset");
        chk(dat_o, 32'h0000_0000, "read data after reset");
        rd(ECSO_IDX_TALLY_ONE, 8'h00, "tally one reset");
        rd(ECSO_IDX_TALLY_TWO, 8'h00, "tally two reset");
        rd(ECSO_IDX_STATUS_CTL, 8'h00, "control reset");
        rd(8'h60, 8'h00, "unmapped read");
        // Status pin table; flags settle before the control write lands
        foreach (rows[i]) begin
            fl <= rows[i].fl;
            wb(1'b1, ECSO_IDX_STATUS_CTL, rows[i].ctl, 4'hf);
            repeat (3) @(posedge clk_i);
            chk(oe_n, rows[i].oe_n, "pin enable");
            if (rows[i].oe_n == 1'b0) chk(wire_lvl, rows[i].pin, "pin level");
        end
        // Inverted event flag; then a write with byte lane 0 off is dropped
        fl <= 6'h08;
        wb(1'b1, ECSO_IDX_STATUS_CTL, 8'h4b, 4'hf);
        repeat (3) @(posedge clk_i);
        chk(wire_lvl, 1'b0, "inverted flag");
        wb(1'b1, ECSO_IDX_STATUS_CTL, 8'hc0, 4'he);
        rd(ECSO_IDX_STATUS_CTL, 8'h4b, "sel lane off");
        wb(1'b1, ECSO_IDX_STATUS_CTL, 8'hff, 4'hf);
        rd(ECSO_IDX_STATUS_CTL, 8'hcf, "control bits");
        // Pin levels on the monitor bits
        i_far.levels(1'b1, 1'b0);
        rd(ECSO_IDX_LEVEL_MON, 8'h20, "monitor one");
        i_far.levels(1'b1, 1'b1);
        rd(ECSO_IDX_LEVEL_MON, 8'h60, "monitor both");
        i_far.levels(1'b0, 1'b0);
        rd(ECSO_IDX_LEVEL_MON, 8'h00, "monitor low");
        // Counting, wrap at 63, and a disabled input
        wb(1'b1, ECSO_IDX_INPUT_EN, 8'h01, 4'hf);
        wb(1'b1, ECSO_IDX_TALLY_ONE, 8'h3f, 4'hf);
        rd(ECSO_IDX_TALLY_ONE, 8'h00, "tally read only");
        i_far.pulse(1, 63);
        repeat (6) @(posedge clk_i);
        rd(ECSO_IDX_TALLY_ONE, 8'h3f, "tally at top");
        i_far.pulse(1, 2);
        i_far.pulse(2, 3);
        repeat (6) @(posedge clk_i);
        rd(ECSO_IDX_TALLY_ONE, 8'h01, "tally wrap");
        rd(ECSO_IDX_TALLY_TWO, 8'h00, "disabled tally");
        wb(1'b1, ECSO_IDX_INPUT_EN, 8'h02, 4'hf);
        i_far.pulse(2, 3);
        i_far.pulse(1, 2);
        repeat (6) @(posedge clk_i);
        rd(ECSO_IDX_TALLY_TWO, 8'h03, "tally two");
        rd(ECSO_IDX_TALLY_ONE, 8'h01, "tally one held");
        // Mid-run reset must clear counts, enables and the pin mode
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(oe_n, 1'b1, "oe after second reset");
        rd(ECSO_IDX_TALLY_TWO, 8'h00, "tally two cleared");
        rd(ECSO_IDX_INPUT_EN, 8'h00, "enables cleared");
        rd(ECSO_IDX_STATUS_CTL, 8'h00, "control cleared");
        tally_and_finish();
    end
endmodule
